// >>> verilog/lefr_pkg.sv
// Constants shared by the link error, flood and retry block
package lefr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS  = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_SERR_EN    = 0;
  localparam int CTRL_BR_SERR_EN = 1;
  localparam int CTRL_RETRY_EN   = 2;
  localparam int CTRL_HOST       = 3;
  localparam int CTRL_BRIDGE     = 4;
  localparam int CTRL_WARM       = 8;
  localparam logic [4:0] CTRL_RST = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Error log index, shared by status and enable fields
  localparam int E_PROT  = 0;
  localparam int E_OVF   = 1;
  localparam int E_EOC   = 2;
  localparam int E_INB   = 3;
  localparam int E_RESP  = 4;
  localparam int E_CRC   = 5;
  localparam int E_SERR  = 6;
  localparam int E_UNREC = 7;
  localparam int FLOOD_LSB    = 0;
  localparam int FATAL_LSB    = 8;
  localparam int NONFATAL_LSB = 16;
  localparam logic [7:0]  FLOOD_MASK = 8'h23;
  localparam logic [7:0]  INTR_MASK  = 8'h77;
  localparam logic [7:0]  HOST_MASK  = 8'h48;
  localparam logic [23:0] ENABLE_RST = 24'h000000;
  localparam logic [7:0]  LOG_RST    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status and state register fields
  localparam int ST_CHAIN_FAIL = 8;
  localparam int ST_SIG_SERR   = 9;
  localparam int SV_FLOOD_LSB  = 0;
  localparam int SV_SYNC_LSB   = 2;
  localparam int SV_RETRY      = 4;
  localparam int SV_ACK0_LSB   = 8;
  localparam int SV_ACK1_LSB   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Link constants
  localparam logic [2:0] SYNC_COUNT = 3'h4;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'hFF;
  localparam logic [7:0] ACK_RST    = 8'h00;
  localparam logic [7:0] ALL_ONES   = 8'hFF;

endpackage : lefr_pkg

// >>> verilog/lefr_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module lefr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end

  assign q_out = q_ff;

endmodule : lefr_sync

// >>> verilog/lefr_crc8.sv
// Byte-serial CRC accumulator for one transmit lane group
`timescale 1ns/10ps
module lefr_crc8 (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       en_in,
  input  wire logic [7:0] data_in,
  // Result
  output logic      [7:0] crc_out
);

  logic [7:0] crc_ff;
  logic [7:0] nxt_crc;

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ lefr_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  assign nxt_crc = clear_in ? lefr_pkg::CRC_INIT :
                   en_in    ? crc_step(crc_ff, data_in) : crc_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      crc_ff <= lefr_pkg::CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc_out = crc_ff;

endmodule : lefr_crc8

// >>> verilog/lefr_top.sv
// Link error handling: sync flood, error routing, retry mode and stomping
`timescale 1ns/10ps

//
// Function
// RL1 - Flooding drives all lanes to ones
// RL2 - Sync seen after init floods every transmitter
// RL3 - Flooding holds until warm reset
// RL4 - Error status survives warm reset
// RL5 - No CRC generated or checked while flooding
// RL6 - Any flooding device sets chain fail
// RL7 - Initiation needs SERR enable, sets signaled error
// RL8 - Bridge notes secondary flood not its own
// RL9 - Secondary flood upward needs both enables
// RL10 - Propagation within chain needs no enable
// RL11 - Bridge floods secondary always, also internally
// RL12 - Log bits route to flood, fatal, nonfatal
// RL13 - Host-only errors reserved in slaves
// RL14 - Retry mode checks CRC, bad packet retries
// RL15 - NOPs carry count of good packets
// RL16 - Exhausted retries raise enabled notification
// RL17 - Retry mode disables periodic CRC
// RL18 - Retry mode changes only at warm reset
// RL19 - Software matches retry enable both ends
// RL20 - Stomped packet sends inverted CRC
// RL21 - Speculative forward only on retry links
// RL22 - Stomped packet dropped quietly, credits freed
// RL23 - Four sync packets before acting on flood
module lefr_top (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // APB slave
  input  wire logic [7:0]      paddr_in,
  input  wire logic            psel_in,
  input  wire logic            penable_in,
  input  wire logic            pwrite_in,
  input  wire logic [31:0]     pwdata_in,
  output logic      [31:0]     prdata_out,
  output logic                 pready_out,
  output logic                 pslverr_out,
  // Link pins, link 0 primary, link 1 secondary
  input  wire logic            link_clk_in,
  input  wire logic [1:0][7:0] command_address_data_lanes_in,
  input  wire logic [1:0]      control_lane_in,
  output logic      [1:0][7:0] command_address_data_lanes_out,
  output logic      [1:0]      control_lane_out,
  // Transmit stream from packet engine
  input  wire logic [1:0]      link_init_done_in,
  input  wire logic [1:0][7:0] tx_byte_in,
  input  wire logic [1:0]      tx_ctl_in,
  input  wire logic [1:0]      tx_crc_slot_in,
  input  wire logic [1:0]      tx_stomp_in,
  input  wire logic [1:0]      tx_info_in,
  // Speculative forwarding checks
  input  wire logic [1:0]      fwd_valid_cmd_in,
  input  wire logic [1:0]      fwd_credit_in,
  input  wire logic [1:0]      fwd_in_time_in,
  output logic      [1:0]      spec_fwd_ok_out,
  // Received packet checks
  input  wire logic [1:0]      rx_pkt_end_in,
  input  wire logic [1:0]      rx_info_in,
  input  wire logic [1:0][7:0] rx_crc_rcv_in,
  input  wire logic [1:0][7:0] rx_crc_calc_in,
  output logic      [1:0]      rx_accept_out,
  output logic      [1:0]      retry_req_out,
  output logic      [1:0]      credit_free_out,
  output logic      [1:0][7:0] nop_ack_out,
  // Error events
  input  wire logic            err_prot_in,
  input  wire logic            err_ovf_in,
  input  wire logic            err_eoc_in,
  input  wire logic            err_inb_eoc_in,
  input  wire logic            err_resp_in,
  input  wire logic            internal_err_in,
  input  wire logic            retry_exhausted_in,
  // Reporting
  output logic                 fatal_out,
  output logic                 nonfatal_out,
  output logic                 periodic_crc_en_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [4:0]  ctrl_ff;
  logic [23:0] enable_ff;
  logic [7:0]  log_ff;
  logic        chain_fail_ff;
  logic        sig_serr_ff;
  logic        warm_ff;
  logic        retry_active_ff;
  logic        sec_self_ff;
  logic [1:0]  flood_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        fatal_ff;
  logic        nonfatal_ff;
  logic        pcrc_en_ff;
  logic        lclk_d_ff;

  // Per-link state
  logic [2:0]  sync_cnt_ff  [2];
  logic        sync_det_ff  [2];
  logic [7:0]  tx_cad_ff    [2];
  logic        tx_ctl_ff    [2];
  logic [7:0]  ack_ff       [2];
  logic        accept_ff    [2];
  logic        retry_req_ff [2];
  logic        credit_ff    [2];
  logic        spec_ok_ff   [2];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and link clock edge
  logic [18:0] pins_s;
  logic        lclk_s;
  logic        lclk_rise;

  lefr_sync #(.WIDTH(19)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({link_clk_in, control_lane_in,
                command_address_data_lanes_in}),
    .q_out    (pins_s)
  );

  assign lclk_s    = pins_s[18];
  assign lclk_rise = lclk_s & ~lclk_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic        setup;
  logic        wr_ctrl;
  logic        wr_enable;
  logic        wr_status;
  logic        mapped;
  logic [31:0] rd_data;
  logic        host;
  logic        bridge;
  logic        serr_en;

  assign setup     = psel_in & ~penable_in;
  assign mapped    = (paddr_in == lefr_pkg::CTRL_OFS) |
                     (paddr_in == lefr_pkg::ENABLE_OFS) |
                     (paddr_in == lefr_pkg::STATUS_OFS) |
                     (paddr_in == lefr_pkg::STATE_OFS);
  assign wr_ctrl   = setup & pwrite_in & (paddr_in == lefr_pkg::CTRL_OFS);
  assign wr_enable = setup & pwrite_in & (paddr_in == lefr_pkg::ENABLE_OFS);
  assign wr_status = setup & pwrite_in & (paddr_in == lefr_pkg::STATUS_OFS);
  assign host      = ctrl_ff[lefr_pkg::CTRL_HOST];
  assign bridge    = ctrl_ff[lefr_pkg::CTRL_BRIDGE];
  assign serr_en   = ctrl_ff[lefr_pkg::CTRL_SERR_EN];

  // Host-only bits read as zero in slaves
  logic [7:0]  res_mask;
  logic [23:0] enable_vis;
  assign res_mask   = host ? 8'hFF : ~lefr_pkg::HOST_MASK; // RL13
  assign enable_vis = enable_ff & {3{res_mask}};

  assign rd_data =
    (paddr_in == lefr_pkg::CTRL_OFS)   ? {27'h0, ctrl_ff} :
    (paddr_in == lefr_pkg::ENABLE_OFS) ? {8'h00, enable_vis} :
    (paddr_in == lefr_pkg::STATUS_OFS) ?
      {22'h0, sig_serr_ff, chain_fail_ff, log_ff} :
    (paddr_in == lefr_pkg::STATE_OFS)  ?
      {8'h00, ack_ff[1], ack_ff[0], 3'h0, retry_active_ff,
       sync_det_ff[1], sync_det_ff[0], flood_ff} :
    32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= (setup & ~pwrite_in) ? rd_data : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-link receive, transmit and packet checks
  logic [1:0] sync_new;
  logic [1:0] crc_bad;
  logic [1:0] crc_bad_ev;

  for (genvar l = 0; l < 2; l++) begin : g_link
    logic       all_ones;
    logic [2:0] nxt_cnt;
    logic [7:0] crc;
    logic       slot;
    logic       stomp;
    logic       stomped;
    logic       good;
    logic [7:0] nxt_cad;

    // Count only on a live link, so a flood seen before init restarts at 0
    assign all_ones = (pins_s[l*8 +: 8] == lefr_pkg::ALL_ONES) &
                      pins_s[16 + l] & link_init_done_in[l]; // RL2
    assign nxt_cnt  = ~all_ones ? 3'h0 :
                      (sync_cnt_ff[l] == lefr_pkg::SYNC_COUNT) ?
                      sync_cnt_ff[l] : sync_cnt_ff[l] + 3'h1;
    // Act only after four consecutive sync samples on a live link
    assign sync_new[l] = lclk_rise & link_init_done_in[l] & // RL2
                         (nxt_cnt == lefr_pkg::SYNC_COUNT); // RL23

    always_ff @(posedge clk_in) begin
      if (!rst_n_in || warm_ff) begin
        sync_cnt_ff[l] <= 3'h0;
        sync_det_ff[l] <= 1'b0;
      end else begin
        sync_cnt_ff[l] <= lclk_rise ? nxt_cnt : sync_cnt_ff[l];
        sync_det_ff[l] <= sync_det_ff[l] | sync_new[l];
      end
    end

    // Transmit: stomp only non-info packets on retry links
    assign slot  = tx_crc_slot_in[l];
    assign stomp = tx_stomp_in[l] & ~tx_info_in[l] & retry_active_ff; // RL21
    assign nxt_cad = flood_ff[l] ? lefr_pkg::ALL_ONES : // RL1
                     ~slot       ? tx_byte_in[l] :
                     stomp       ? ~crc : crc; // RL20

    lefr_crc8 u_crc (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .clear_in (lclk_rise & slot),
      .en_in    (lclk_rise & ~slot & ~flood_ff[l]), // RL5
      .data_in  (tx_byte_in[l]),
      .crc_out  (crc)
    );

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        tx_cad_ff[l] <= 8'h00;
        tx_ctl_ff[l] <= 1'b0;
      end else if (lclk_rise) begin
        tx_cad_ff[l] <= nxt_cad;
        tx_ctl_ff[l] <= flood_ff[l] | tx_ctl_in[l]; // RL1
      end
    end

    // Receive: per-packet check in retry mode, none once sync is seen
    assign stomped = retry_active_ff & ~rx_info_in[l] &
                     (rx_crc_rcv_in[l] == ~rx_crc_calc_in[l]);
    assign crc_bad[l] = retry_active_ff & ~sync_det_ff[l] & ~stomped &
                        (rx_crc_rcv_in[l] != rx_crc_calc_in[l]); // RL5
    assign good = ~sync_det_ff[l] & ~stomped & ~crc_bad[l];
    assign crc_bad_ev[l] = rx_pkt_end_in[l] & crc_bad[l];

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        accept_ff[l]    <= 1'b0;
        retry_req_ff[l] <= 1'b0;
        credit_ff[l]    <= 1'b0;
        spec_ok_ff[l]   <= 1'b0;
      end else begin
        accept_ff[l]    <= rx_pkt_end_in[l] & good;
        retry_req_ff[l] <= crc_bad_ev[l]; // RL14
        credit_ff[l]    <= rx_pkt_end_in[l] & stomped; // RL22
        spec_ok_ff[l]   <= retry_active_ff & ~flood_ff[l] &
                           fwd_valid_cmd_in[l] & fwd_credit_in[l] &
                           fwd_in_time_in[l]; // RL21
      end
    end

    // Count of good non-info packets carried by each NOP
    always_ff @(posedge clk_in) begin
      if (!rst_n_in || warm_ff) begin
        ack_ff[l] <= lefr_pkg::ACK_RST;
      end else if (rx_pkt_end_in[l] & good & ~rx_info_in[l] &
                   retry_active_ff) begin
        ack_ff[l] <= ack_ff[l] + 8'h01; // RL15
      end
    end

    assign command_address_data_lanes_out[l] = tx_cad_ff[l];
    assign control_lane_out[l] = tx_ctl_ff[l];
    assign nop_ack_out[l]      = ack_ff[l];
    assign rx_accept_out[l]    = accept_ff[l];
    assign retry_req_out[l]    = retry_req_ff[l];
    assign credit_free_out[l]  = credit_ff[l];
    assign spec_fwd_ok_out[l]  = spec_ok_ff[l];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error logging and routing
  logic [7:0] log_set;
  logic [7:0] route;
  logic [7:0] flood_en;
  logic [7:0] fatal_en;
  logic [7:0] nonfatal_en;
  logic       flood_req;
  logic       initiate;
  logic       sec_up;
  logic [1:0] nxt_flood;

  assign log_set = {retry_exhausted_in, // RL16
                    bridge & sync_new[1] & ~sec_self_ff, // RL8
                    |crc_bad_ev, err_resp_in, err_inb_eoc_in,
                    err_eoc_in, err_ovf_in, err_prot_in} & res_mask; // RL13
  // In retry mode the checksum enables serve unrecoverable errors
  assign route = retry_active_ff ?
                 {1'b0, log_ff[6], log_ff[7], log_ff[4:0]} :
                 {1'b0, log_ff[6:0]}; // RL17
  assign flood_en    = enable_vis[lefr_pkg::FLOOD_LSB +: 8];
  assign fatal_en    = enable_vis[lefr_pkg::FATAL_LSB +: 8];
  assign nonfatal_en = enable_vis[lefr_pkg::NONFATAL_LSB +: 8];
  assign flood_req   = |(route & flood_en & lefr_pkg::FLOOD_MASK); // RL12
  assign initiate    = flood_req & serr_en & ~flood_ff[0]; // RL7
  assign sec_up      = sync_new[1] & ctrl_ff[lefr_pkg::CTRL_BR_SERR_EN] &
                       serr_en; // RL9
  // Plain devices flood everywhere, bridges gate the upward direction
  assign nxt_flood[0] = flood_ff[0] | initiate | sync_new[0] |
                        (bridge ? sec_up : sync_new[1]); // RL10
  assign nxt_flood[1] = flood_ff[1] | initiate | sync_new[0] |
                        sync_new[1] | (bridge & internal_err_in); // RL11

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || warm_ff) begin
      flood_ff    <= 2'b00;
      sec_self_ff <= 1'b0;
    end else begin
      flood_ff    <= nxt_flood; // RL3
      sec_self_ff <= sec_self_ff | initiate | (bridge & internal_err_in);
    end
  end

  // Status is sticky: only cold reset or write-one-to-clear, set wins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      log_ff        <= lefr_pkg::LOG_RST;
      chain_fail_ff <= 1'b0;
      sig_serr_ff   <= 1'b0;
    end else begin
      log_ff        <= (log_ff & ~({8{wr_status}} & pwdata_in[7:0])) |
                       log_set; // RL4
      chain_fail_ff <= (chain_fail_ff &
                        ~(wr_status & pwdata_in[lefr_pkg::ST_CHAIN_FAIL])) |
                       (|flood_ff); // RL6
      sig_serr_ff   <= (sig_serr_ff &
                        ~(wr_status & pwdata_in[lefr_pkg::ST_SIG_SERR])) |
                       initiate; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, warm reset and retry mode
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_ff   <= lefr_pkg::CTRL_RST;
      enable_ff <= lefr_pkg::ENABLE_RST;
      warm_ff   <= 1'b0;
    end else begin
      ctrl_ff   <= wr_ctrl ? pwdata_in[4:0] : ctrl_ff;
      enable_ff <= wr_enable ? pwdata_in[23:0] : enable_ff;
      warm_ff   <= wr_ctrl & pwdata_in[lefr_pkg::CTRL_WARM];
    end
  end

  // Mode follows the enable only at warm reset, never at link stop
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      retry_active_ff <= 1'b0;
    end else if (warm_ff) begin
      retry_active_ff <= ctrl_ff[lefr_pkg::CTRL_RETRY_EN]; // RL18
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fatal_ff    <= 1'b0;
      nonfatal_ff <= 1'b0;
      pcrc_en_ff  <= 1'b0;
      lclk_d_ff   <= 1'b0;
    end else begin
      fatal_ff    <= |(route & fatal_en & lefr_pkg::INTR_MASK); // RL12
      nonfatal_ff <= |(route & nonfatal_en & lefr_pkg::INTR_MASK);
      pcrc_en_ff  <= ~retry_active_ff & ~(|flood_ff); // RL17
      lclk_d_ff   <= lclk_s;
    end
  end

  assign prdata_out          = prdata_ff;
  assign pready_out          = pready_ff;
  assign pslverr_out         = pslverr_ff;
  assign fatal_out           = fatal_ff;
  assign nonfatal_out        = nonfatal_ff;
  assign periodic_crc_en_out = pcrc_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  flood_ones_a: assert property (lclk_rise && flood_ff[0] |=> // RL1
    command_address_data_lanes_out[0] == 8'hFF && control_lane_out[0])
    else $error("flooding link not driving ones");
  flood_hold_a: assert property (flood_ff[0] && !warm_ff |=> // RL3
    flood_ff[0]) else $error("flood dropped without warm reset");
  sync_spread_a: assert property (sync_new[0] && !warm_ff |=> // RL2
    flood_ff == 2'b11) else $error("sync not spread to all links");
  serr_gate_a: assert property ($rose(sig_serr_ff) |-> // RL7
    $past(serr_en) && $rose(flood_ff[0]))
    else $error("flood initiated without enable");
  chain_fail_a: assert property (|flood_ff |=> chain_fail_ff) // RL6
    else $error("chain fail not set");
  log_keep_a: assert property (warm_ff && !$past(wr_status) |-> // RL4
    (log_ff & $past(log_ff)) == $past(log_ff))
    else $error("status lost at warm reset");
  crc_retry_a: assert property (crc_bad_ev[0] |=> // RL14
    retry_req_out[0] && !rx_accept_out[0])
    else $error("bad packet not retried");
  stomp_quiet_a: assert property (rx_pkt_end_in[0] && retry_active_ff && // RL22
    !rx_info_in[0] && rx_crc_rcv_in[0] == ~rx_crc_calc_in[0] |=>
    credit_free_out[0] && !retry_req_out[0] && !rx_accept_out[0])
    else $error("stomped packet mishandled");
  mode_keep_a: assert property (!$past(warm_ff) |-> // RL18
    $stable(retry_active_ff)) else $error("mode changed outside warm");
  sync_count_a: assert property ($rose(sync_det_ff[0]) |-> // RL23
    $past(sync_cnt_ff[0]) == 3'h3) else $error("flood acted early");

  flood_c: cover property ($rose(flood_ff[0]));
  retry_c: cover property (retry_req_out[0]);
  stomp_c: cover property (credit_free_out[0]);
  warm_c:  cover property (warm_ff ##1 retry_active_ff);

endmodule : lefr_top

// >>> tb/lefr_peer.sv
// Far-side link neighbour: link clock and receive lanes
`timescale 1ns/10ps
module lefr_peer (
  // Control
  input  wire logic            run_in,
  input  wire logic            flood_in,
  // Link pins
  output logic                 lclk_out,
  output logic      [1:0][7:0] lanes_out,
  output logic      [1:0]      ctl_out
);
  logic [7:0] pat;
  initial begin
    lclk_out = 1'b0;
    pat = 8'h00;
    lanes_out = '0;
    ctl_out = 2'h0;
    #17;
    forever begin
      #160;
      lclk_out = run_in & ~lclk_out;
      // Idle traffic changes once per link clock period, control low
      if (!lclk_out) pat = pat + 8'h01;
      lanes_out[0] = flood_in ? 8'hFF : pat;
      lanes_out[1] = ~pat;
      ctl_out = {1'b0, flood_in};
    end
  end
endmodule : lefr_peer

// >>> tb/tb.sv
// Self-checking bench for the link error handling block
`timescale 1ns/10ps
module tb;
  logic            clk_in, rst_n_in, psel, penable, pwrite, pready;
  logic            pslverr, lclk, pflood, fatal, nonfatal, pcrc_en;
  logic [7:0]      paddr, lfsr;
  logic [31:0]     pwdata, prdata;
  logic [1:0][7:0] rx_lanes, tx_lanes, tx_byte, crc_rcv, crc_calc, ack;
  logic [1:0]      rx_ctl, tx_ctl, tctl, txz, init_done, pkt_end, fwd;
  logic [1:0]      fwd_ok, accept, retry_req, cfree;
  logic [6:0]      err;
  logic [32:0]     exp_q[$];
  int              n_errors, n_checks, e;
  lefr_peer u_peer (.run_in(rst_n_in), .flood_in(pflood),
    .lclk_out(lclk), .lanes_out(rx_lanes), .ctl_out(rx_ctl));
  lefr_top u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link_clk_in(lclk),
    .command_address_data_lanes_in(rx_lanes), .control_lane_in(rx_ctl),
    .command_address_data_lanes_out(tx_lanes), .control_lane_out(tx_ctl),
    .link_init_done_in(init_done), .tx_byte_in(tx_byte),
    .tx_ctl_in(tctl), .tx_crc_slot_in(txz), .tx_stomp_in(txz),
    .tx_info_in(txz), .fwd_valid_cmd_in(fwd), .fwd_credit_in(fwd),
    .fwd_in_time_in(fwd), .spec_fwd_ok_out(fwd_ok),
    .rx_pkt_end_in(pkt_end), .rx_info_in(txz), .rx_crc_rcv_in(crc_rcv),
    .rx_crc_calc_in(crc_calc), .rx_accept_out(accept),
    .retry_req_out(retry_req), .credit_free_out(cfree),
    .nop_ack_out(ack), .err_prot_in(err[0]), .err_ovf_in(err[1]),
    .err_eoc_in(err[2]), .err_inb_eoc_in(err[3]), .err_resp_in(err[4]),
    .internal_err_in(err[5]), .retry_exhausted_in(err[6]),
    .fatal_out(fatal), .nonfatal_out(nonfatal),
    .periodic_crc_en_out(pcrc_en));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [7:0] nxt_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt_rand
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [32:0] g, input logic [32:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk_in);
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk_in);
    err[k] <= 1'b1;
    @(posedge clk_in);
    err[k] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : pulse
  task automatic pkt(input logic [7:0] r, c, input logic [2:0] m, x);
    @(posedge clk_in);
    crc_rcv[0] <= r;
    crc_calc[0] <= c;
    pkt_end[0] <= 1'b1;
    @(posedge clk_in);
    pkt_end[0] <= 1'b0;
    @(posedge clk_in);
    cmp(33'({accept[0], retry_req[0], cfree[0]} & m), 33'(x));
  endtask : pkt
  task automatic wait_lane(input int l, input logic [7:0] v);
    int i;
    for (i = 0; i < 600 && tx_lanes[l] !== v; i++) @(posedge clk_in);
    cmp(33'(tx_lanes[l]), 33'(v));
    if (i == 600) give_verdict();
  endtask : wait_lane
  // Read results are checked in order as the bus completes them
  always @(posedge clk_in) begin
    if (psel && penable && pready && !pwrite) begin
      cmp({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    {rst_n_in, psel, penable, pwrite, pflood, paddr, pwdata} = '0;
    {txz, init_done, pkt_end, fwd, err, crc_rcv, crc_calc} = '0;
    lfsr = nxt_rand(8'h2F);
    tx_byte = {lfsr & 8'h7F, nxt_rand(lfsr) & 8'h7F};
    tctl = lfsr[1:0];
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(lefr_pkg::CTRL_OFS, 33'h0);
    rd(lefr_pkg::STATE_OFS, 33'h0);
    rd(8'h10, 33'h100000000);
    apb(1'b1, lefr_pkg::ENABLE_OFS, 32'hFFFFFFFF);
    rd(lefr_pkg::ENABLE_OFS, 33'hB7B7B7);
    cmp(33'(pcrc_en), 33'h1);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      e = (k == 3) ? 4 : k;
      apb(1'b1, lefr_pkg::ENABLE_OFS, 32'h1 << (8 + 8 * k[0] + e));
      pulse(e);
      cmp(33'({fatal, nonfatal}), k[0] ? 33'h1 : 33'h2);
      rd(lefr_pkg::STATUS_OFS, 33'h1 << e);
      apb(1'b1, lefr_pkg::STATUS_OFS, 32'h1 << e);
      repeat (3) @(posedge clk_in);
      cmp(33'({fatal, nonfatal}), 33'h0);
    end
    $display("test routing done");
    apb(1'b1, lefr_pkg::ENABLE_OFS, 32'h2000);
    apb(1'b1, lefr_pkg::CTRL_OFS, 32'h104);
    repeat (3) @(posedge clk_in);
    fwd <= 2'h3;
    rd(lefr_pkg::STATE_OFS, 33'h10);
    cmp(33'({pcrc_en, fwd_ok}), 33'h3);
    lfsr = nxt_rand(lfsr);
    pkt(lfsr, lfsr, 3'h6, 3'h4);
    pkt(lfsr, lfsr ^ 8'h01, 3'h6, 3'h2);
    pkt(lfsr, ~lfsr, 3'h7, 3'h1);
    cmp(33'(ack[0]), 33'h1);
    cmp(33'(fatal), 33'h0);
    pulse(6);
    cmp(33'(fatal), 33'h1);
    rd(lefr_pkg::STATUS_OFS, 33'hA0);
    apb(1'b1, lefr_pkg::STATUS_OFS, 32'hA0);
    $display("test retry done");
    apb(1'b1, lefr_pkg::ENABLE_OFS, 32'h1);
    apb(1'b1, lefr_pkg::CTRL_OFS, 32'h1);
    pulse(0);
    wait_lane(0, 8'hFF);
    wait_lane(1, 8'hFF);
    repeat (100) @(posedge clk_in);
    cmp({tx_lanes, tx_ctl, pcrc_en, fwd_ok}, 33'h1FFFF8);
    rd(lefr_pkg::STATUS_OFS, 33'h301);
    apb(1'b1, lefr_pkg::CTRL_OFS, 32'h100);
    wait_lane(0, tx_byte[0]);
    cmp(33'(tx_ctl), 33'(tctl));
    rd(lefr_pkg::STATUS_OFS, 33'h301);
    rd(lefr_pkg::STATE_OFS, 33'h0);
    apb(1'b1, lefr_pkg::STATUS_OFS, 32'h301);
    $display("test flood done");
    pflood <= 1'b1;
    repeat (100) @(posedge clk_in);
    cmp(33'(tx_lanes[1]), 33'(tx_byte[1]));
    init_done <= 2'h3;
    wait_lane(1, 8'hFF);
    rd(lefr_pkg::STATE_OFS, 33'h7);
    rd(lefr_pkg::STATUS_OFS, 33'h100);
    $display("test propagation done");
    give_verdict();
  end
endmodule : tb
